// ---- ffmd_pkg.sv ----
// Shared constants of the freefall/motion event detector
package ffmd_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FFMD_CFG_ADDR = 8'h15;
    localparam logic [7:0] FFMD_SRC_ADDR = 8'h16;
    localparam logic [7:0] FFMD_THS_ADDR = 8'h17;
    localparam logic [7:0] FFMD_CNT_ADDR = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FFMD_CFG_LATCH_BIT   = 7;
    localparam int FFMD_CFG_COMBINE_BIT = 6;
    localparam int FFMD_CFG_EN_LSB      = 3;
    localparam int FFMD_THS_DBM_BIT     = 7;
    localparam int FFMD_SRC_EVT_BIT     = 7;
    localparam int FFMD_NUM_AXES        = 3;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] FFMD_CFG_RST = 8'h00;
    localparam logic [7:0] FFMD_THS_RST = 8'h00;
    localparam logic [7:0] FFMD_CNT_RST = 8'h00;
    localparam logic [7:0] FFMD_ZERO8   = 8'h00;
endpackage

// ---- ffmd_axis_if.sv ----
// Per-axis compare results passed from the comparator to the detector core
`timescale 1ns/1ns
interface ffmd_axis_if #(parameter int N = 3);
    logic [N-1:0] high;
    logic [N-1:0] low;
    logic [N-1:0] neg;
    modport drv (output high, output low, output neg);
    modport rcv (input high, input low, input neg);
endinterface

// ---- ffmd_axis_cmp.sv ----
// Magnitude and sign compare of every axis sample against the threshold
`timescale 1ns/1ns
module ffmd_axis_cmp #(
    parameter int ACC_W = 8
) (
    // Samples, axis 0 in the low bits
    input  wire logic [3*ACC_W-1:0] acc_all,
    // Unsigned threshold in counts
    input  wire logic [6:0]         thresh,
    // Results
    ffmd_axis_if.drv                res
);
    import ffmd_pkg::*;

    // Absolute value one bit wider so the most negative code does not wrap
    function automatic logic [ACC_W:0] mag(input logic [ACC_W-1:0] v);
        logic [ACC_W:0] ext;
        ext = {v[ACC_W-1], v};
        mag = v[ACC_W-1] ? (~ext + 1'b1) : ext;
    endfunction

    // ------------------------------------------------------------
    // One comparator per axis
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < FFMD_NUM_AXES; g++) begin : g_axis
            logic [ACC_W-1:0] s;
            logic [ACC_W:0]   m;
            logic [ACC_W:0]   t;
            // High above threshold, low below it, equal is neither
            always_comb begin
                s = acc_all[g*ACC_W +: ACC_W];
                m = mag(s);
                t = (ACC_W + 1)'(thresh);
                res.high[g] = m > t;
                res.low[g]  = m < t;
                res.neg[g]  = s[ACC_W-1];
            end
        end
    endgenerate
endmodule

// ---- ffmd_core.sv ----
// Freefall/motion event detector: registers, debounce counter, event and axis flags
`timescale 1ns/1ns
module ffmd_core #(
    parameter int ACC_W = 8
) (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // Sample stream, one tick per output sample
    input  wire logic                    sample_tick,
    input  wire logic signed [ACC_W-1:0] accel_x,
    input  wire logic signed [ACC_W-1:0] accel_y,
    input  wire logic signed [ACC_W-1:0] accel_z,
    // Register port
    input  wire logic [7:0]              reg_addr,
    input  wire logic                    reg_wr_en,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_rd_en,
    output logic      [7:0]              reg_rdata,
    // Status
    output logic                         event_active_flag
);
    import ffmd_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] ths_q;
    logic [7:0] ths_d;
    logic [7:0] dbc_q;
    logic [7:0] dbc_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       evt_q;
    logic       evt_d;
    logic [5:0] flg_q;
    logic [5:0] flg_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [2:0] axis_en;
    logic       any_en;
    logic       latch_en;
    logic       combine_sel;
    logic       dbc_mode;
    logic       cond;
    logic       src_rd;
    logic       set_evt;
    logic [5:0] live;
    logic [5:0] flg_vis;

    ffmd_axis_if #(.N(FFMD_NUM_AXES)) axr ();

    // ------------------------------------------------------------
    // Axis comparators
    // ------------------------------------------------------------
    ffmd_axis_cmp #(.ACC_W(ACC_W)) ffmd_axis_cmp_i (
        .acc_all ({accel_z, accel_y, accel_x}),
        .thresh  (ths_q[6:0]),
        .res     (axr)
    );

    // ------------------------------------------------------------
    // Decoded configuration and detection condition
    // ------------------------------------------------------------
    always_comb begin
        axis_en     = cfg_q[FFMD_CFG_EN_LSB +: 3];
        any_en      = |axis_en;
        latch_en    = cfg_q[FFMD_CFG_LATCH_BIT];
        combine_sel = cfg_q[FFMD_CFG_COMBINE_BIT];
        dbc_mode    = ths_q[FFMD_THS_DBM_BIT];
        src_rd      = reg_rd_en && (reg_addr == FFMD_SRC_ADDR);
        // Disabled axes count as satisfied for AND and as silent for OR
        if (combine_sel) begin
            cond = |(axr.high & axis_en);
        end else begin
            cond = any_en && (&(axr.low | ~axis_en));
        end
        // Flag pairs per axis: high-g above, polarity below
        for (int i = 0; i < FFMD_NUM_AXES; i++) begin
            live[2*i+1]    = axr.high[i] && axis_en[i];
            live[2*i]      = axr.high[i] && axr.neg[i] && axis_en[i];
            flg_vis[2*i+1] = flg_q[2*i+1] && axis_en[i];
            flg_vis[2*i]   = flg_q[2*i] && axis_en[i];
        end
    end

    // ------------------------------------------------------------
    // Configuration registers, written by software
    // ------------------------------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        ths_d = ths_q;
        dbc_d = dbc_q;
        if (reg_wr_en) begin
            unique case (reg_addr)
                FFMD_CFG_ADDR: cfg_d = {reg_wdata[7:3], 3'h0};
                FFMD_THS_ADDR: ths_d = reg_wdata;
                FFMD_CNT_ADDR: dbc_d = reg_wdata;
                default:       cfg_d = cfg_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_q <= FFMD_CFG_RST;
            ths_q <= FFMD_THS_RST;
            dbc_q <= FFMD_CNT_RST;
        end else begin
            cfg_q <= cfg_d;
            ths_q <= ths_d;
            dbc_q <= dbc_d;
        end
    end

    // ------------------------------------------------------------
    // Debounce counter, event flag and axis flags
    // ------------------------------------------------------------
    // A read that meets a fresh event keeps the event; set wins over clear
    always_comb begin
        cnt_d   = cnt_q;
        evt_d   = evt_q;
        flg_d   = flg_q;
        set_evt = 1'b0;
        if (!any_en) begin
            cnt_d = FFMD_ZERO8;
            evt_d = 1'b0;
            flg_d = 6'h00;
        end else begin
            if (sample_tick) begin
                if (cond) begin
                    // Clamp also covers a count lowered under the counter
                    cnt_d = (cnt_q < dbc_q) ? cnt_q + 8'h01 : dbc_q;
                end else if (dbc_mode) begin
                    cnt_d = FFMD_ZERO8;
                end else if (cnt_q != FFMD_ZERO8) begin
                    cnt_d = cnt_q - 8'h01;
                end
                set_evt = cond && (cnt_d == dbc_q);
                if (!latch_en) begin
                    flg_d = live;
                    if (set_evt) begin
                        evt_d = 1'b1;
                    end else if (!cond && (dbc_mode || cnt_d == FFMD_ZERO8)) begin
                        evt_d = 1'b0;
                    end
                end else begin
                    if (!evt_q) begin
                        flg_d = live;           // Frozen once the event is up
                    end
                    if (set_evt) begin
                        evt_d = 1'b1;
                    end
                end
            end
            // Only the latched modes react to a source read
            if (latch_en && src_rd && !set_evt) begin
                evt_d = 1'b0;
                cnt_d = FFMD_ZERO8;
                flg_d = 6'h00;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= FFMD_ZERO8;
            evt_q <= 1'b0;
            flg_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
            evt_q <= evt_d;
            flg_q <= flg_d;
        end
    end

    // ------------------------------------------------------------
    // Read data, registered so outputs come from flops
    // ------------------------------------------------------------
    // Flags of a disabled axis read as zero even if latched earlier
    always_comb begin
        rdata_d = FFMD_ZERO8;
        if (reg_rd_en) begin
            unique case (reg_addr)
                FFMD_CFG_ADDR: rdata_d = cfg_q;
                FFMD_SRC_ADDR: rdata_d = {evt_q, 1'b0, flg_vis};
                FFMD_THS_ADDR: rdata_d = ths_q;
                FFMD_CNT_ADDR: rdata_d = dbc_q;
                default:       rdata_d = FFMD_ZERO8;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= FFMD_ZERO8;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata         = rdata_q;
    assign event_active_flag = evt_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Write cycles are left out where a new count could legally move state
    AST_CNT_BOUND: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_tick && any_en && cond && !reg_wr_en |=> cnt_q <= dbc_q)
        else $error("debounce counter above programmed count");

    AST_DISABLED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !any_en |=> cnt_q == FFMD_ZERO8 && !evt_q && flg_q == 6'h00)
        else $error("detector active with all axes disabled");

    AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        latch_en && any_en && evt_q && !src_rd && !reg_wr_en |=> evt_q)
        else $error("latched event flag dropped without a read");

    AST_READ_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        latch_en && any_en && src_rd && !set_evt && !reg_wr_en
        |=> !evt_q && cnt_q == FFMD_ZERO8 && flg_q == 6'h00)
        else $error("latched source read did not clear state");

    AST_LIVE_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !latch_en && any_en && src_rd && !sample_tick && !reg_wr_en
        |=> $stable(evt_q) && $stable(cnt_q) && $stable(flg_q))
        else $error("live mode source read changed state");

    AST_FLAGS_FROZEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        latch_en && any_en && evt_q && !src_rd && !reg_wr_en |=> $stable(flg_q))
        else $error("latched axis flags changed during event");

    AST_CLEAR_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_tick && any_en && !cond && dbc_mode |=> cnt_q == FFMD_ZERO8)
        else $error("counter not cleared in clear mode");

    AST_DEC_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_tick && any_en && !cond && !dbc_mode && cnt_q != FFMD_ZERO8 && !(latch_en && src_rd)
        |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("counter did not step down by one");

    // Next state uses the old config, so a write in the same cycle is harmless
    AST_LIVE_DROP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !latch_en && dbc_mode && sample_tick && any_en && !cond |=> !evt_q)
        else $error("live event flag held after condition ended");

    AST_LIVE_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !latch_en && any_en && sample_tick |=> flg_q == $past(live))
        else $error("live axis flags do not follow compare");

    AST_SET_AT_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_tick && any_en && cond && cnt_q + 9'h001 >= {1'b0, dbc_q} |=> evt_q)
        else $error("event flag not set at programmed count");

    AST_NO_TICK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !sample_tick && !src_rd && !reg_wr_en && any_en |=> $stable(cnt_q) && $stable(evt_q))
        else $error("state moved without a sample tick");

    AST_HOLD_DEC: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !latch_en && !dbc_mode && any_en && evt_q && cnt_q > 8'h01 |=> evt_q)
        else $error("event flag dropped before counter ran down");

    AST_LIVE_RUNDOWN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !latch_en && !dbc_mode && any_en && sample_tick && !cond && cnt_q == 8'h01 |=> !evt_q)
        else $error("live event flag held after counter ran down");

    AST_LATCH_TRACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        latch_en && any_en && !evt_q && sample_tick && !src_rd |=> flg_q == $past(live))
        else $error("latched axis flags did not track before the event");

    AST_NO_EARLY_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_tick && any_en && !evt_q && cnt_q + 9'h001 < {1'b0, dbc_q} |=> !evt_q)
        else $error("event flag set before the debounce count");

    AST_POLARITY_PAIR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (flg_q & ~(flg_q >> 1) & 6'h15) == 6'h00)
        else $error("polarity flag set without its high-g flag");
endmodule

// ---- test_freefall_motion_event_detector.sv ----
// Self-checking testbench of the freefall/motion event detector core
`timescale 1ns/1ns
module test_freefall_motion_event_detector;
    import ffmd_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic              clk_sys     = 1'b0;
    logic              rst_n       = 1'b0;
    logic              sample_tick = 1'b0;
    logic signed [7:0] accel_x     = 8'sh00;
    logic signed [7:0] accel_y     = 8'sh00;
    logic signed [7:0] accel_z     = 8'sh00;
    logic [7:0]        reg_addr    = 8'h00;
    logic              reg_wr_en   = 1'b0;
    logic [7:0]        reg_wdata   = 8'h00;
    logic              reg_rd_en   = 1'b0;
    logic [7:0]        reg_rdata;
    logic              event_active_flag;
    logic              rd_seen     = 1'b0;
    logic [7:0]        exp_q[$];
    int                num_errors  = 0;
    int                checks      = 0;
    int                seed        = 32'hB363;
    int                ax[3];
    int                tv;
    logic [2:0]        en;
    logic [7:0]        e;

    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    ffmd_core #(.ACC_W(8)) ffmd_core_i (
        .clk_sys           (clk_sys),
        .rst_n             (rst_n),
        .sample_tick       (sample_tick),
        .accel_x           (accel_x),
        .accel_y           (accel_y),
        .accel_z           (accel_z),
        .reg_addr          (reg_addr),
        .reg_wr_en         (reg_wr_en),
        .reg_wdata         (reg_wdata),
        .reg_rd_en         (reg_rd_en),
        .reg_rdata         (reg_rdata),
        .event_active_flag (event_active_flag)
    );

    // ------------------------------------------------------------
    // Compare, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask

    // Read strobe is one cycle; the expected byte is noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        exp_q.push_back(x);
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
    endtask

    task automatic tk(input int x, input int y, input int z);
        @(posedge clk_sys);
        accel_x <= 8'(x);
        accel_y <= 8'(y);
        accel_z <= 8'(z);
        sample_tick <= 1'b1;
        @(posedge clk_sys);
        sample_tick <= 1'b0;
    endtask

    // Disabling first flushes counter and flags left by the last scenario
    task automatic setup(input logic [7:0] c, input logic [7:0] t, input logic [7:0] n);
        wr(FFMD_CFG_ADDR, 8'h00);
        wr(FFMD_THS_ADDR, t);
        wr(FFMD_CNT_ADDR, n);
        wr(FFMD_CFG_ADDR, c);
    endtask

    // ------------------------------------------------------------
    // Monitor: read data one cycle after the strobe, flag mid-cycle
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rd_seen && exp_q.size() > 0) begin
            cmp(reg_rdata, exp_q.pop_front());
        end
        rd_seen <= reg_rd_en;
    end

    // Flag port mirrors source bit 7 just before the read is taken
    always @(negedge clk_sys) begin
        if (reg_rd_en === 1'b1 && reg_addr === FFMD_SRC_ADDR && exp_q.size() > 0) begin
            cmp({7'h00, event_active_flag}, {7'h00, exp_q[exp_q.size()-1][7]});
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(FFMD_CFG_ADDR, FFMD_CFG_RST);
        rd(FFMD_SRC_ADDR, 8'h00);
        rd(FFMD_THS_ADDR, FFMD_THS_RST);
        rd(FFMD_CNT_ADDR, FFMD_CNT_RST);
        wr(FFMD_CFG_ADDR, 8'hFF);
        rd(FFMD_CFG_ADDR, 8'hF8);
        wr(FFMD_SRC_ADDR, 8'h55);
        rd(FFMD_SRC_ADDR, 8'h00);
        rd(8'h20, 8'h00);
        wr(FFMD_THS_ADDR, 8'hA5);
        rd(FFMD_THS_ADDR, 8'hA5);
        wr(FFMD_CNT_ADDR, 8'h3C);
        rd(FFMD_CNT_ADDR, 8'h3C);
        $display("test registers done");
        // Live motion, clear mode, count 2; equal magnitude is not high
        setup(8'h78, 8'h8A, 8'h02);
        tk(10, 0, -10); rd(FFMD_SRC_ADDR, 8'h00);
        tk(11, 0, 0);   rd(FFMD_SRC_ADDR, 8'h02);
        tk(-11, 0, 0);  rd(FFMD_SRC_ADDR, 8'h83);
        rd(FFMD_SRC_ADDR, 8'h83);
        tk(0, 0, 0);    rd(FFMD_SRC_ADDR, 8'h00);
        // Live motion, decrement mode; extra true tick must not overcount
        setup(8'h78, 8'h0A, 8'h02);
        repeat (3) tk(0, 20, 0);
        rd(FFMD_SRC_ADDR, 8'h88);
        tk(0, 0, 0);    rd(FFMD_SRC_ADDR, 8'h80);
        tk(0, 0, 0);    rd(FFMD_SRC_ADDR, 8'h00);
        $display("test motion live done");
        // Live freefall on x and y only, clear mode, count 1
        setup(8'h18, 8'h8A, 8'h01);
        tk(5, -5, 100); rd(FFMD_SRC_ADDR, 8'h80);
        rd(FFMD_SRC_ADDR, 8'h80);
        tk(5, -20, 0);  rd(FFMD_SRC_ADDR, 8'h0C);
        tk(5, 5, 0);    rd(FFMD_SRC_ADDR, 8'h80);
        // Live freefall, decrement mode, count 2
        setup(8'h18, 8'h0A, 8'h02);
        repeat (2) tk(1, 1, 0);
        tk(20, 0, 0);   rd(FFMD_SRC_ADDR, 8'h82);
        tk(20, 0, 0);   rd(FFMD_SRC_ADDR, 8'h02);
        $display("test freefall live done");
        // Latched freefall, count 2: flags frozen, read clears
        setup(8'h98, 8'h8A, 8'h02);
        tk(1, 1, 0);    rd(FFMD_SRC_ADDR, 8'h00);
        repeat (2) tk(1, 1, 0);
        tk(-20, -20, 0);
        rd(FFMD_SRC_ADDR, 8'h80);
        rd(FFMD_SRC_ADDR, 8'h00);
        tk(-20, 1, 0);  rd(FFMD_SRC_ADDR, 8'h03);
        // A latched read without a fresh event restarts the count, so the event needs two fresh ticks
        tk(1, 1, 0);    rd(FFMD_SRC_ADDR, 8'h00);
        repeat (2) tk(1, 1, 0);
        rd(FFMD_SRC_ADDR, 8'h80);
        $display("test freefall latched done");
        // Latched motion, count 0: hold, clear on read, then disable
        setup(8'hF8, 8'h0A, 8'h00);
        tk(0, -20, 0);
        tk(20, 0, 0);   rd(FFMD_SRC_ADDR, 8'h8C);
        rd(FFMD_SRC_ADDR, 8'h00);
        tk(20, 0, 0);   rd(FFMD_SRC_ADDR, 8'h82);
        wr(FFMD_CFG_ADDR, 8'h40);
        rd(FFMD_SRC_ADDR, 8'h00);
        tk(100, -100, 100); rd(FFMD_SRC_ADDR, 8'h00);
        $display("test motion latched done");
        // Random samples and thresholds, live motion with count 0
        for (int i = 0; i < 24; i++) begin
            en = 3'($random(seed));
            if (en == 3'h0) en = 3'h1;
            tv = $random(seed) & 127;
            setup({2'h1, en, 3'h0}, {1'b1, 7'(tv)}, 8'h00);
            e = 8'h00;
            for (int k = 0; k < 3; k++) begin
                ax[k] = $random(seed) % 128;
                if (en[k] && (ax[k] > tv || -ax[k] > tv)) begin
                    e = e | (8'h02 << (2 * k)) | ((ax[k] < 0) ? (8'h01 << (2 * k)) : 8'h00);
                end
            end
            if (e != 8'h00) e = e | 8'h80;
            tk(ax[0], ax[1], ax[2]);
            rd(FFMD_SRC_ADDR, e);
        end
        $display("test random done");
        // Bounded drain of outstanding reads
        for (int w = 0; w < 20 && exp_q.size() > 0; w++) @(posedge clk_sys);
        if (exp_q.size() > 0) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, exp_q.size(), 0);
        end
        give_verdict();
    end
endmodule
